// [src/lbp_pkg.sv]
// package of constants and types for the lcd bias panel control block
package lbp_pkg;
  localparam int GAMMA_CHANNELS = 14;
  localparam int GAMMA_WIDTH = 10;
  localparam int GAMMA_MSB_BITS = 2;
  localparam int GAMMA_LSB_BITS = 8;
  localparam int COMMON_ELECTRODE_VOLTAGE_WIDTH = 7;
  localparam int BYTE_ADDR_WIDTH = 6;
  localparam int DELAY_SET_WIDTH = 8;
  // first gamma byte register; each channel takes an upper then a lower byte
  localparam logic [5:0] GAMMA_BASE_ADDR = 6'h0c;
  localparam logic [5:0] GAMMA_LAST_ADDR = 6'h27;
  localparam logic [1:0] GAMMA_MSB_RESET = 2'h2;
  localparam logic [7:0] GAMMA_LSB_RESET = 8'h00;
  localparam logic [6:0] COMMON_ELECTRODE_VOLTAGE_RESET = 7'h00;
  // shaping delay counted in 1 ms ticks, at most 35 ms
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int DELAY_MAX_MS = 35;
  localparam logic [7:0] DELAY_MAX_CODE = 8'h23;
  typedef enum logic [2:0] {
    LBP_OFF,
    LBP_LOAD,
    LBP_RAMP,
    LBP_DELAY,
    LBP_RUN,
    LBP_DOWN
  } lbp_seq_t;
endpackage

// [src/lbp_store_if.sv]
// interface joining the sequencer to the gamma/common_electrode_voltage code store
`timescale 1ns/1ps
`default_nettype none
interface lbp_store_if;
  import lbp_pkg::*;
  logic load;
  logic load_done;
  logic save;
  logic save_busy;
  logic [GAMMA_CHANNELS*GAMMA_WIDTH-1:0] gamma_flat;
  logic [COMMON_ELECTRODE_VOLTAGE_WIDTH-1:0] common_electrode_voltage_code;
  modport seq(output load, output save, input load_done, input save_busy, input gamma_flat, input common_electrode_voltage_code);
  modport store(input load, input save, output load_done, output save_busy, output gamma_flat, output common_electrode_voltage_code);
endinterface
`default_nettype wire

// [src/lbp_code_store.sv]
// gamma and common_electrode_voltage code store with non-volatile default image
`timescale 1ns/1ps
`default_nettype none
module lbp_code_store
  import lbp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // sequencer side
  lbp_store_if.store st,
  // register write port
  input wire logic wr_en,
  input wire logic [BYTE_ADDR_WIDTH-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic common_electrode_voltage_wr_en,
  input wire logic [COMMON_ELECTRODE_VOLTAGE_WIDTH-1:0] common_electrode_voltage_wr_data,
  input wire logic common_electrode_voltage_save
);
  // volatile working codes and the non-volatile image; the image survives rst
  logic [GAMMA_WIDTH-1:0] ram_r [GAMMA_CHANNELS];
  logic [GAMMA_WIDTH-1:0] ram_nxt [GAMMA_CHANNELS];
  // the image starts at the factory codes, as a blank part would ship
  logic [GAMMA_WIDTH-1:0] nvm_r [GAMMA_CHANNELS] = '{default: {GAMMA_MSB_RESET, GAMMA_LSB_RESET}};
  logic [GAMMA_WIDTH-1:0] nvm_nxt [GAMMA_CHANNELS];
  logic [COMMON_ELECTRODE_VOLTAGE_WIDTH-1:0] vram_r, vram_nxt, vnvm_nxt;
  logic [COMMON_ELECTRODE_VOLTAGE_WIDTH-1:0] vnvm_r = COMMON_ELECTRODE_VOLTAGE_RESET;
  logic done_r, done_nxt;
  logic [BYTE_ADDR_WIDTH-1:0] rel;

  assign rel = wr_addr - GAMMA_BASE_ADDR;

  always_comb begin
    done_nxt = st.load;
    vram_nxt = vram_r;
    vnvm_nxt = vnvm_r;
    for (int i = 0; i < GAMMA_CHANNELS; i++) begin
      ram_nxt[i] = ram_r[i];
      nvm_nxt[i] = nvm_r[i];
      if (st.load) begin
        ram_nxt[i] = nvm_r[i]; // see [RQ14]
      end else if (wr_en && wr_addr >= GAMMA_BASE_ADDR && wr_addr <= GAMMA_LAST_ADDR &&
                   rel[BYTE_ADDR_WIDTH-1:1] == (BYTE_ADDR_WIDTH-1)'(i)) begin
        // upper byte then lower byte per channel
        if (rel[0] == 1'b0) begin
          ram_nxt[i][GAMMA_WIDTH-1:GAMMA_LSB_BITS] = wr_data[GAMMA_MSB_BITS-1:0]; // see [RQ20] see [RQ13]
        end else begin
          ram_nxt[i][GAMMA_LSB_BITS-1:0] = wr_data; // see [RQ20] see [RQ16]
        end
      end
      if (st.save) begin
        nvm_nxt[i] = ram_r[i]; // see [RQ15]
      end
    end
    // common_electrode_voltage is its own category with its own save
    if (st.load) begin
      vram_nxt = vnvm_r; // see [RQ18]
    end else if (common_electrode_voltage_wr_en) begin
      vram_nxt = common_electrode_voltage_wr_data; // see [RQ9]
    end
    if (common_electrode_voltage_save) begin
      vnvm_nxt = vram_r; // see [RQ18]
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < GAMMA_CHANNELS; i++) begin
        ram_r[i] <= {GAMMA_MSB_RESET, GAMMA_LSB_RESET};
      end
      vram_r <= COMMON_ELECTRODE_VOLTAGE_RESET;
      done_r <= 1'b0;
    end else begin
      ram_r <= ram_nxt;
      vram_r <= vram_nxt;
      done_r <= done_nxt;
    end
  end

  // the image is deliberately not reset: it models storage kept across power loss
  always_ff @(posedge mclk) begin
    nvm_r <= nvm_nxt;
    vnvm_r <= vnvm_nxt;
  end

  always_comb begin
    for (int i = 0; i < GAMMA_CHANNELS; i++) begin
      st.gamma_flat[i*GAMMA_WIDTH +: GAMMA_WIDTH] = ram_r[i];
    end
  end
  assign st.common_electrode_voltage_code = vram_r;
  assign st.load_done = done_r;
  assign st.save_busy = 1'b0;
endmodule
`default_nettype wire

// [src/lbp_panel_control.sv]
// top of the lcd bias panel control: gate shaping, panel reset, dac codes
// Contract
// [RQ1] shaping input high in run: pass switch on, discharge switch off.
// [RQ2] shaping input falling edge: pass switch off, discharge switch on.
// [RQ3] power-up: discharge on, pass off until shaping delay after ramp done.
// [RQ4] power-down: pass switch on, discharge off, shaping input ignored.
// [RQ5] unused shaping: tie input static, leave discharge resistor pin open.
// [RQ6] gate-in-panel select 0: panel reset low while supply below detect threshold.
// [RQ7] gate-in-panel select 1: panel reset low until shaping delay after ramp.
// [RQ8] panel reset is open drain: drive low or release only.
// [RQ9] hold 7-bit common electrode code; larger code means more sink current.
// [RQ10] common electrode code spans 0 to 127.
// [RQ11] shutdown select 0: common electrode discharge always off.
// [RQ12] shutdown select 1: discharge on when supply under lockout level.
// [RQ13] fourteen gamma channels, each writable individually in operation.
// [RQ14] at power-up load every gamma code from storage.
// [RQ15] save command copies current codes into storage as defaults.
// [RQ16] gamma codes are 10-bit unsigned, 0 to 1023.
// [RQ17] host should set unused gamma channels to maximum code.
// [RQ18] common electrode setting is a separate configuration category.
// [RQ19] host holds write protect low for any access; high blocks traffic.
// [RQ20] each gamma code is an upper 2-bit byte and lower 8-bit byte.
// [RQ21] overrides come from internal ramp-done and shutdown status.
`timescale 1ns/1ps
`default_nettype none
module lbp_panel_control
  import lbp_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pins from outside
  input wire logic gate_shaping_control_input,
  input wire logic write_protect,
  // internal sequencing status
  input wire logic power_good,
  input wire logic gate_high_rail_ramp_done,
  input wire logic shutdown,
  input wire logic supply_below_detect,
  input wire logic supply_below_uvlo,
  // configuration
  input wire logic gate_in_panel_select,
  input wire logic common_electrode_shutdown_select,
  input wire logic [DELAY_SET_WIDTH-1:0] shaping_delay_setting,
  // register writes from the serial interface
  input wire logic reg_wr_en,
  input wire logic [BYTE_ADDR_WIDTH-1:0] reg_wr_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic save_cmd,
  input wire logic common_electrode_voltage_wr_en,
  input wire logic [COMMON_ELECTRODE_VOLTAGE_WIDTH-1:0] common_electrode_voltage_wr_data,
  input wire logic common_electrode_voltage_save_cmd,
  // switch and panel outputs
  output logic pass_switch,
  output logic discharge_switch,
  output logic panel_reset_output_out,
  output logic panel_reset_output_oe,
  output logic common_electrode_discharge,
  // dac codes
  output logic [COMMON_ELECTRODE_VOLTAGE_WIDTH-1:0] common_electrode_voltage_dac_code,
  output logic [GAMMA_CHANNELS*GAMMA_WIDTH-1:0] gamma_dac_codes,
  output logic codes_loaded
);
  lbp_store_if sif();

  // pin synchronisers
  logic shp_s1_r, shp_s2_r, shp_d_r, wp_s1_r, wp_s2_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shp_s1_r <= 1'b0;
      shp_s2_r <= 1'b0;
      shp_d_r <= 1'b0;
      wp_s1_r <= 1'b1;
      wp_s2_r <= 1'b1;
    end else begin
      shp_s1_r <= gate_shaping_control_input;
      shp_s2_r <= shp_s1_r;
      shp_d_r <= shp_s2_r;
      wp_s1_r <= write_protect;
      wp_s2_r <= wp_s1_r;
    end
  end

  // write protect high drops all register traffic
  logic wr_ok;
  assign wr_ok = ~wp_s2_r; // see [RQ19]

  // sequencer
  lbp_seq_t st_r, st_nxt;
  logic [31:0] tick_r, tick_nxt;
  logic [DELAY_SET_WIDTH-1:0] ms_r, ms_nxt, dly_lim;
  logic load_r, load_nxt;

  assign dly_lim = (shaping_delay_setting > DELAY_MAX_CODE) ? DELAY_MAX_CODE : shaping_delay_setting;

  always_comb begin
    st_nxt = st_r;
    tick_nxt = tick_r;
    ms_nxt = ms_r;
    load_nxt = 1'b0;
    unique case (st_r)
      LBP_OFF: begin
        if (power_good) begin
          st_nxt = LBP_LOAD;
          load_nxt = 1'b1;
        end
      end
      LBP_LOAD: begin
        if (sif.load_done) begin
          st_nxt = LBP_RAMP;
        end
      end
      LBP_RAMP: begin
        tick_nxt = '0;
        ms_nxt = '0;
        if (gate_high_rail_ramp_done) begin
          st_nxt = LBP_DELAY; // see [RQ21]
        end
      end
      LBP_DELAY: begin
        if (ms_r >= dly_lim) begin
          st_nxt = LBP_RUN; // see [RQ3]
        end else if (tick_r == 32'(TICK_CYC - 1)) begin
          tick_nxt = '0;
          ms_nxt = ms_r + 8'h01;
        end else begin
          tick_nxt = tick_r + 32'h1;
        end
      end
      LBP_RUN: begin
      end
      LBP_DOWN: begin
      end
    endcase
    if (shutdown && st_r != LBP_OFF) begin
      st_nxt = LBP_DOWN; // see [RQ21]
    end
    if (!power_good && !shutdown) begin
      st_nxt = LBP_OFF;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= LBP_OFF;
      tick_r <= '0;
      ms_r <= '0;
      load_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tick_r <= tick_nxt;
      ms_r <= ms_nxt;
      load_r <= load_nxt;
    end
  end

  assign sif.load = load_r;
  assign sif.save = save_cmd & wr_ok; // see [RQ15]

  lbp_code_store u_store (
    .mclk(mclk),
    .rst(rst),
    .st(sif),
    .wr_en(reg_wr_en & wr_ok),
    .wr_addr(reg_wr_addr),
    .wr_data(reg_wr_data),
    .common_electrode_voltage_wr_en(common_electrode_voltage_wr_en & wr_ok),
    .common_electrode_voltage_wr_data(common_electrode_voltage_wr_data),
    .common_electrode_voltage_save(common_electrode_voltage_save_cmd & wr_ok)
  );

  // output stage
  logic pass_nxt, dis_nxt, xao_low_nxt, cdis_nxt, run;
  logic pass_r, dis_r, xao_low_r, cdis_r, loaded_r, loaded_nxt;
  logic [COMMON_ELECTRODE_VOLTAGE_WIDTH-1:0] common_electrode_voltage_r;
  logic [GAMMA_CHANNELS*GAMMA_WIDTH-1:0] gam_r;
  assign run = (st_r == LBP_RUN);

  always_comb begin
    pass_nxt = pass_r;
    dis_nxt = dis_r;
    if (st_r == LBP_DOWN) begin
      pass_nxt = 1'b1; // see [RQ4]
      dis_nxt = 1'b0;
    end else if (!run) begin
      pass_nxt = 1'b0; // see [RQ3]
      dis_nxt = 1'b1;
    end else if (shp_s2_r) begin
      pass_nxt = 1'b1; // see [RQ1]
      dis_nxt = 1'b0;
    end else if (shp_d_r) begin
      pass_nxt = 1'b0; // see [RQ2]
      dis_nxt = 1'b1;
    end
    if (gate_in_panel_select) begin
      xao_low_nxt = !run; // see [RQ7]
    end else begin
      xao_low_nxt = supply_below_detect; // see [RQ6]
    end
    cdis_nxt = common_electrode_shutdown_select & supply_below_uvlo; // see [RQ11] see [RQ12]
    loaded_nxt = (st_r == LBP_OFF || st_r == LBP_LOAD) ? 1'b0 : 1'b1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pass_r <= 1'b0;
      dis_r <= 1'b1;
      xao_low_r <= 1'b1;
      cdis_r <= 1'b0;
      loaded_r <= 1'b0;
      common_electrode_voltage_r <= COMMON_ELECTRODE_VOLTAGE_RESET;
      gam_r <= '0;
    end else begin
      pass_r <= pass_nxt;
      dis_r <= dis_nxt;
      xao_low_r <= xao_low_nxt;
      cdis_r <= cdis_nxt;
      loaded_r <= loaded_nxt;
      common_electrode_voltage_r <= sif.common_electrode_voltage_code; // see [RQ10]
      gam_r <= sif.gamma_flat;
    end
  end

  // open drain: output data fixed low, only the enable moves
  assign pass_switch = pass_r;
  assign discharge_switch = dis_r;
  assign panel_reset_output_out = 1'b0; // see [RQ8]
  assign panel_reset_output_oe = xao_low_r; // see [RQ8]
  assign common_electrode_discharge = cdis_r;
  assign common_electrode_voltage_dac_code = common_electrode_voltage_r;
  assign gamma_dac_codes = gam_r;
  assign codes_loaded = loaded_r;
endmodule
`default_nettype wire

// [sim/lbp_panel_model.sv]
// far side model: gate driver reset pin with pull-up and the modulated rail level
`timescale 1ns/1ps
`default_nettype none
module lbp_panel_model (
  // switch drives
  input wire logic pass_switch,
  input wire logic discharge_switch,
  // open-drain reset pin
  input wire logic panel_reset_output_oe,
  input wire logic panel_reset_output_out,
  // levels seen by the panel
  output logic panel_reset_n,
  output logic rail_high
);
  // the pull-up gives the high level whenever nobody pulls the line
  assign panel_reset_n = panel_reset_output_oe ? panel_reset_output_out : 1'h1;
  // rail bleeds to 0 through the resistor; floats if neither switch conducts
  assign rail_high = pass_switch ? 1'h1 : (discharge_switch ? 1'h0 : 1'hz);
endmodule
`default_nettype wire

// [sim/lbp_panel_control_assertions.sv]
// concurrent checks on the lcd bias panel control ports
`timescale 1ns/1ps
`default_nettype none
module lbp_chk
  import lbp_pkg::*;
(
  // clock and reset
  input wire logic mclk, rst,
  // inputs
  input wire logic gate_shaping_control_input, write_protect, gate_high_rail_ramp_done, shutdown,
  input wire logic supply_below_detect, supply_below_uvlo, gate_in_panel_select, common_electrode_shutdown_select,
  input wire logic reg_wr_en,
  input wire logic [BYTE_ADDR_WIDTH-1:0] reg_wr_addr,
  input wire logic [7:0] reg_wr_data,
  // outputs
  input wire logic pass_switch, discharge_switch, panel_reset_output_out, panel_reset_output_oe,
  input wire logic common_electrode_discharge,
  input wire logic [GAMMA_CHANNELS*GAMMA_WIDTH-1:0] gamma_dac_codes
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_OD_LOW: assert property (!panel_reset_output_out)
    else $error("panel reset driven high");
  AST_SW_PAIR: assert property (pass_switch != discharge_switch)
    else $error("switches not complementary");
  AST_DOWN: assert property (shutdown [*4] |-> pass_switch && !discharge_switch)
    else $error("power-down override missing");
  AST_UP_HOLD: assert property ((!gate_high_rail_ramp_done && !shutdown) [*3] |-> discharge_switch)
    else $error("discharge released before ramp");
  AST_FALL: assert property ($fell(gate_shaping_control_input) && !shutdown |-> ##[1:4] discharge_switch)
    else $error("no discharge after falling input");
  AST_CDIS_OFF: assert property (!common_electrode_shutdown_select [*2] |-> !common_electrode_discharge)
    else $error("common discharge on while disabled");
  AST_CDIS_ON: assert property (common_electrode_shutdown_select && supply_below_uvlo
    |-> ##[1:2] common_electrode_discharge)
    else $error("common discharge missing");
  AST_DET: assert property (!gate_in_panel_select && supply_below_detect |-> ##[1:3] panel_reset_output_oe)
    else $error("panel reset not pulled on low supply");
  AST_GIP: assert property ((gate_in_panel_select && !gate_high_rail_ramp_done && !shutdown) [*2]
    |-> panel_reset_output_oe)
    else $error("panel reset released before ramp");
  AST_WR_LO: assert property ((!write_protect) [*3] ##0 (reg_wr_en && reg_wr_addr == 6'h0d)
    |-> ##2 gamma_dac_codes[7:0] == $past(reg_wr_data, 2))
    else $error("lower byte write lost");
  cover property ($rose(pass_switch));
  cover property ($rose(common_electrode_discharge));
  cover property (reg_wr_en && write_protect);
endmodule
bind lbp_panel_control lbp_chk chk (.*);
`default_nettype wire

// [sim/lbp_panel_control_test.sv]
// self-checking bench for the lcd bias panel control block
`timescale 1ns/1ps
`default_nettype none
module lbp_panel_control_test;
  import lbp_pkg::*;
  localparam int TK = 10;
  logic mclk = 1'h0, rst = 1'h1, shp = 1'h1, write_protect = 1'h0, power_good = 1'h0, rdone = 1'h0;
  logic shutdown = 1'h0, supply_below_detect = 1'h0, supply_below_uvlo = 1'h0, gate_in_panel_select = 1'h1;
  logic common_electrode_shutdown_select = 1'h0, reg_wr_en = 1'h0, save_cmd = 1'h0;
  logic common_electrode_voltage_wr_en = 1'h0, common_electrode_voltage_save_cmd = 1'h0;
  logic [7:0] shaping_delay_setting = 8'h03, reg_wr_data = 8'h00;
  logic [5:0] reg_wr_addr = 6'h00;
  logic [6:0] common_electrode_voltage_wr_data = 7'h00, common_electrode_voltage_dac_code;
  logic pass_switch, discharge_switch, panel_reset_output_out, panel_reset_output_oe;
  logic common_electrode_discharge, codes_loaded, panel_reset_n, rail_high;
  logic [GAMMA_CHANNELS*GAMMA_WIDTH-1:0] gamma_dac_codes;
  logic [9:0] exp_g [GAMMA_CHANNELS];
  int bad_count = 0, samples_checked = 0, t0;

  always #10 mclk = ~mclk;
  lbp_panel_control #(.TICK_CYC(TK)) dut (.gate_shaping_control_input(shp), .gate_high_rail_ramp_done(rdone), .*);
  lbp_panel_model panel (.*);

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic c1(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cv(input string nm, input logic [9:0] e, input logic [9:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one idle cycle after each pulse so a strobe is never set twice in one step
  task automatic pulse(ref logic s);
    s = 1'h1;
    step(1);
    s = 1'h0;
    step(1);
  endtask
  task automatic wr(input int a, input logic [7:0] d);
    reg_wr_addr = 6'(a);
    reg_wr_data = d;
    pulse(reg_wr_en);
  endtask
  task automatic power_up();
    rst = 1'h1;
    power_good = 1'h0;
    rdone = 1'h0;
    step(2);
    rst = 1'h0;
    step(3);
    power_good = 1'h1;
    step(8);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #80000;
    bad_count++;
    wrap_up();
  end

  initial begin
    power_up();
    c1("discharge", 1'h1, discharge_switch);
    c1("panel reset", 1'h0, panel_reset_n);
    c1("loaded", 1'h1, codes_loaded);
    for (int i = 0; i < GAMMA_CHANNELS; i++) cv("default", 10'h200, gamma_dac_codes[i*10 +: 10]);
    rdone = 1'h1;
    t0 = 0;
    while (pass_switch !== 1'h1 && t0 < 200) begin
      step(1);
      t0++;
    end
    c1("delay", 1'h1, t0 >= 3 * TK && t0 <= 3 * TK + 6);
    step(2);
    c1("panel reset", 1'h1, panel_reset_n);
    $display("test power-up done");
    shp = 1'h0;
    step(5);
    c1("rail", 1'h0, rail_high);
    shp = 1'h1;
    step(5);
    c1("rail", 1'h1, rail_high);
    $display("test shaping done");
    for (int i = 0; i < GAMMA_CHANNELS; i++) begin
      // top channel at full code, as an unused output would be
      exp_g[i] = (i == GAMMA_CHANNELS - 1) ? 10'h3ff : 10'(i * 71 + 3);
      wr(GAMMA_BASE_ADDR + 2 * i, {6'h00, exp_g[i][9:8]});
      wr(GAMMA_BASE_ADDR + 2 * i + 1, exp_g[i][7:0]);
    end
    wr(GAMMA_LAST_ADDR + 1, 8'hff);
    write_protect = 1'h1;
    step(3);
    wr(GAMMA_BASE_ADDR + 1, 8'h5a);
    write_protect = 1'h0;
    step(3);
    for (int i = 0; i < GAMMA_CHANNELS; i++) cv("gamma", exp_g[i], gamma_dac_codes[i*10 +: 10]);
    $display("test gamma writes done");
    supply_below_uvlo = 1'h1;
    step(3);
    c1("cdis", 1'h0, common_electrode_discharge);
    common_electrode_shutdown_select = 1'h1;
    step(3);
    c1("cdis", 1'h1, common_electrode_discharge);
    supply_below_uvlo = 1'h0;
    gate_in_panel_select = 1'h0;
    supply_below_detect = 1'h1;
    step(4);
    c1("panel reset", 1'h0, panel_reset_n);
    supply_below_detect = 1'h0;
    step(4);
    c1("panel reset", 1'h1, panel_reset_n);
    $display("test supply monitors done");
    common_electrode_voltage_wr_data = 7'h7f;
    pulse(common_electrode_voltage_wr_en);
    step(2);
    cv("common_electrode_voltage", 10'h07f, {3'h0, common_electrode_voltage_dac_code});
    pulse(common_electrode_voltage_save_cmd);
    step(20);
    pulse(save_cmd);
    step(20);
    common_electrode_voltage_wr_data = 7'h00;
    pulse(common_electrode_voltage_wr_en);
    wr(GAMMA_BASE_ADDR + 1, 8'h00);
    step(2);
    cv("common_electrode_voltage", 10'h000, {3'h0, common_electrode_voltage_dac_code});
    power_up();
    for (int i = 0; i < GAMMA_CHANNELS; i++) cv("saved", exp_g[i], gamma_dac_codes[i*10 +: 10]);
    cv("saved common_electrode_voltage", 10'h07f, {3'h0, common_electrode_voltage_dac_code});
    $display("test save and reload done");
    shp = 1'h0;
    shutdown = 1'h1;
    step(5);
    c1("pass", 1'h1, pass_switch);
    c1("rail", 1'h1, rail_high);
    $display("test power-down done");
    wrap_up();
  end
endmodule
`default_nettype wire
